/* dv/gtr_host_model.sv */
// application processor side of the video port: a sink that can stall
module gtr_host_model (
    input wire logic clk_in,
    input wire logic hold_in,
    input wire logic valid_in,
    input wire logic sat_in,
    input wire logic [11:0] data_in,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] mem [0:63];
    int n;
    initial ready_out = 1'b0;
    // words are kept with their flag; the bench drops it for grayscale
    always @(posedge clk_in)
    begin
        if (valid_in && ready_out)
        begin
            mem[n] <= {sat_in, data_in};
            n <= n + 1;
        end
        ready_out <= #1 !hold_in;
    end
endmodule

/* dv/gtr_readout_assertions.sv */
module gtr_readout_assertions (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [1:0] phase_sel_out,
    input wire logic amp_stage_en_out,
    input wire logic illum_en_out,
    input wire logic low_sens_out,
    input wire logic pix_ready_out,
    input wire logic video_valid_out,
    input wire logic video_ready_in,
    input wire logic [11:0] video_data_out,
    input wire logic vsync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_gray_one_phase: assert property (low_sens_out
        |-> phase_sel_out == 2'h0)
        else $error("phase moved during grayscale");
    a_amp_gray_only: assert property (amp_stage_en_out
        |-> low_sens_out)
        else $error("amplifier stage outside grayscale");
    a_amp_holds: assert property ($rose(amp_stage_en_out)
        |-> amp_stage_en_out [*8])
        else $error("amplifier stage dropped early");
    a_amp_no_read: assert property (amp_stage_en_out
        |-> !pix_ready_out)
        else $error("readout during integration");
    a_illum_no_read: assert property (illum_en_out
        |-> !pix_ready_out)
        else $error("illumination during readout");
    a_video_holds: assert property (video_valid_out && !video_ready_in
        |=> video_valid_out && $stable(video_data_out))
        else $error("video word changed while stalled");
    a_vsync_drained: assert property ($rose(vsync_out)
        |-> !$past(video_valid_out))
        else $error("frame end before drain");
    a_vsync_quiet: assert property (vsync_out
        |-> !video_valid_out && !pix_ready_out)
        else $error("data moving after frame end");
endmodule

bind gtr_readout gtr_readout_assertions i_gtr_readout_assertions (
    .ref_clk_in, .sys_rst_in, .phase_sel_out, .amp_stage_en_out,
    .illum_en_out, .low_sens_out, .pix_ready_out, .video_valid_out,
    .video_ready_in, .video_data_out, .vsync_out);

/* dv/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, scl, sda_m, sh, pv, hold, vrdy, vval, vsat, vsync;
    logic sda_o, sda_oe, amp, ill, lows, prdy;
    logic [1:0] ph;
    logic [11:0] vdat;
    logic [63:0] temp;
    logic [7:0] d;
    int pn, mismatches, check_count, cyc, ill_n, amp_n, ph3_n, lows_n;
    int i0, a0, p0, n0, l0;
    // open-drain data line with pull-up
    wire sda_w = sda_m & ~(sda_oe & ~sda_o);
    // pixel stream: 2047, then small negatives, flag on odd words
    function automatic logic [12:0] pw(input int k);
        pw = {k[0], (k[2:0] == 3'h0) ? 12'h7ff : 12'h000 - 12'(k[2:0])};
    endfunction
    wire [12:0] pnw = pw(pn);
    gtr_readout #(.INT_CYCLES(20), .PIXELS(8), .CAL0(8'h5a)) i_gtr_readout (
        .ref_clk_in(clk), .sys_rst_in(rst), .i2c_scl_in(scl),
        .i2c_sda_in(sda_w), .i2c_sda_out(sda_o), .i2c_sda_oe_out(sda_oe),
        .shutter_in(sh), .phase_sel_out(ph), .amp_stage_en_out(amp),
        .illum_en_out(ill), .low_sens_out(lows), .pix_valid_in(pv),
        .pix_ready_out(prdy), .pix_data_in(pnw[11:0]), .pix_sat_in(pnw[12]),
        .temp_in(temp), .video_valid_out(vval), .video_ready_in(vrdy),
        .video_data_out(vdat), .video_sat_out(vsat), .vsync_out(vsync));
    gtr_host_model i_gtr_host_model (.clk_in(clk), .hold_in(hold),
        .valid_in(vval), .sat_in(vsat), .data_in(vdat), .ready_out(vrdy));
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // activity counters, pixel source and hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        ill_n <= ill_n + int'(ill);
        amp_n <= amp_n + int'(amp);
        ph3_n <= ph3_n + int'(ph == 2'h3);
        lows_n <= lows_n + int'(lows);
        if (pv && prdy)
            pn <= pn + 1;
        if (cyc == 60000)
        begin
            mismatches++;
            report_and_stop;
        end
    end
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
        check_count++;
        if (seen !== ex)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task hc;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // one bit: data while scl low, sampled with scl high
    task bc(input logic b, output logic r);
        sda_m = b;
        hc;
        scl = 1;
        hc;
        r = sda_w;
        scl = 0;
        hc;
    endtask
    task st;
        sda_m = 1;
        hc;
        scl = 1;
        hc;
        sda_m = 0;
        hc;
        scl = 0;
        hc;
    endtask
    task sp;
        sda_m = 0;
        hc;
        scl = 1;
        hc;
        sda_m = 1;
        hc;
    endtask
    task wb(input logic [7:0] b, input logic ea);
        logic r;
        for (int i = 7; i >= 0; i--)
            bc(b[i], r);
        bc(1'b1, r);
        chk("ack", r, !ea);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        st;
        wb(8'h44, 1);
        wb(a, 1);
        wb(v, 1);
        sp;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        logic r;
        st;
        wb(8'h44, 1);
        wb(a, 1);
        st;
        wb(8'h45, 1);
        for (int i = 0; i < 8; i++)
        begin
            bc(1'b1, r);
            v = {v[6:0], r};
        end
        bc(1'b1, r);
        sp;
    endtask
    task wv;
        int k;
        k = 0;
        while (vsync !== 1'b1 && k < 3000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("vsync", vsync, 1'b1);
    endtask
    task mark;
        i0 = ill_n;
        a0 = amp_n;
        p0 = ph3_n;
        n0 = i_gtr_host_model.n;
        l0 = lows_n;
    endtask
    task shot;
        sh = 1;
        repeat (4) @(posedge clk);
        #1 sh = 0;
    endtask
    // high byte then low byte per sensor
    task tchk(input logic [63:0] t);
        int s;
        for (int a = 0; a < 8; a++)
        begin
            rd(8'h60 + 8'(a), d);
            s = 16 * (a / 2) + 8 * (1 - a % 2);
            chk("temp", d, 8'(t >> s));
        end
    endtask
    // grayscale words drop the flag, which carries no meaning there
    task vchk(input int j);
        logic [12:0] m;
        logic [12:0] w;
        m = (j < 32) ? 13'h1fff : 13'h0fff;
        w = i_gtr_host_model.mem[j] & m;
        chk("video", 16'(w), 16'(pw(j) & m));
    endtask
    initial
    begin
        rst = 1;
        scl = 1;
        sda_m = 1;
        sh = 0;
        pv = 1;
        hold = 0;
        temp = 64'h1234_5678_9abc_def0;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        repeat (4) @(posedge clk);
        #1;
        rd(8'h3c, d);
        chk("gray_cfg", d, 8'h26);
        rd(8'h92, d);
        chk("mode", d, 8'h00);
        rd(8'he8, d);
        chk("cal0", d, 8'h5a);
        rd(8'hee, d);
        chk("cal3", d, 8'h80);
        rd(8'h10, d);
        chk("unmapped", d, 8'h00);
        wr(8'h60, 8'h55);
        rd(8'h60, d);
        chk("temp_ro", d, 8'h00);
        st;
        wb(8'h46, 0);
        sp;
        // normal frame by shutter, sink stalled until the buffer refuses
        mark;
        hold = 1;
        shot;
        repeat (400) @(posedge clk);
        #1 chk("full", prdy, 1'b0);
        hold = 0;
        wv;
        chk("words4", 16'(i_gtr_host_model.n - n0), 16'd32);
        chk("phase3", 16'(ph3_n > p0), 16'd1);
        chk("illum", 16'(ill_n > i0), 16'd1);
        chk("amp", 16'(amp_n - a0), 16'd0);
        chk("full_sens", 16'(lows_n - l0), 16'd0);
        rd(8'h60, d);
        chk("no_latch", d, 8'h00);
        // ambient grayscale by register trigger
        wr(8'h92, 8'hc4);
        mark;
        wr(8'ha4, 8'h01);
        wv;
        chk("words1", 16'(i_gtr_host_model.n - n0), 16'd8);
        chk("ambient", 16'(ill_n - i0), 16'd0);
        chk("amp_int", 16'(amp_n - a0), 16'd20);
        chk("low_sens", 16'(lows_n > l0), 16'd1);
        temp = 64'hfedc_0102_a5a5_7f80;
        tchk(64'h1234_5678_9abc_def0);
        // illuminated grayscale by shutter
        wr(8'h3c, 8'h27);
        rd(8'h3c, d);
        chk("cfg_rw", d, 8'h27);
        mark;
        shot;
        wv;
        chk("lit", 16'(ill_n > i0), 16'd1);
        tchk(64'hfedc_0102_a5a5_7f80);
        chk("total", 16'(i_gtr_host_model.n), 16'd48);
        // flag ignored on grayscale words
        for (int j = 0; j < i_gtr_host_model.n; j++)
            vchk(j);
        report_and_stop;
    end
endmodule

/* verilog/gtr_consts.vh */
`ifndef GTR_CONSTS_VH
`define GTR_CONSTS_VH
// register addresses
`define GTR_ADDR_GRAY_CFG 8'h3c
`define GTR_ADDR_MODE 8'h92
`define GTR_ADDR_TRIGGER 8'ha4
`define GTR_ADDR_TEMP_BASE 8'h60
`define GTR_ADDR_TEMP_LAST 8'h67
`define GTR_ADDR_CAL_BASE 8'he8
// reset and command values
`define GTR_GRAY_CFG_RESET 8'h26
`define GTR_MODE_RESET 8'h00
`define GTR_MODE_GRAYSCALE 8'hc4
`define GTR_TRIGGER_CMD 8'h01
// field position: illumination enable inside the grayscale config
`define GTR_CFG_ILLUM_BIT 0
// phase samples per frame, outside grayscale and in grayscale
`define GTR_PHASES_NORMAL 3'h4
`define GTR_PHASES_GRAY 3'h1
// integration time in ns and clock period in ns
`define GTR_INT_TIME_NS 1000
`define GTR_CLK_PERIOD_NS 8
`define GTR_INT_CYCLES \
    ((`GTR_INT_TIME_NS + `GTR_CLK_PERIOD_NS - 1) / `GTR_CLK_PERIOD_NS)
`define GTR_PIXELS 76800
// i2c slave address, arbitrary value
`define GTR_I2C_DEV_ADDR 7'h22
`endif

/* verilog/gtr_readout.v */
// What this block does
// - in grayscale mode only the first phase sample is acquired.
// - grayscale readout uses the readout amplifier stage, on all integration.
// - each pixel leaves as a signed 12-bit value of plus or minus 2047.
// - valid data is 0 to +2047 and small negatives pass without clipping.
// - the grayscale settings live in register grayscale_measurement_config, which resets to 0x26.
// - grayscale works with illumination off (ambient) or on.
// - every pixel carries a saturation flag for distance measurements.
// - four temperature values become readable at temperature_result_bank after grayscale.
// - each sensor has a stored offset calibration referenced to 27 C.
// - the temperature grayscale shot runs at 2.5 times lower sensitivity.
// - writing 0xc4 to mode register 0x92 selects grayscale acquisition.
// - acquisition starts on a trigger write or a hardware shutter pulse.
// - vertical sync goes high once the image has been transferred.
`include "gtr_consts.vh"

module gtr_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != {(AW+1){1'b0}});
    assign out_data_out = mem[rptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // pointers wrap on power-of-two depth only
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wptr <= wptr + 1'b1;
            if (pop)
                rptr <= rptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

    // storage needs no reset
    always @(posedge ref_clk_in)
    begin
        if (push)
            mem[wptr] <= in_data_in;
    end
endmodule

module gtr_readout #(
    parameter INT_CYCLES = `GTR_INT_CYCLES,
    parameter PIXELS = `GTR_PIXELS,
    parameter [7:0] CAL0 = 8'h80,
    parameter [7:0] CAL1 = 8'h80,
    parameter [7:0] CAL2 = 8'h80,
    parameter [7:0] CAL3 = 8'h80
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire i2c_scl_in,
    input wire i2c_sda_in,
    output wire i2c_sda_out,
    output reg i2c_sda_oe_out,
    input wire shutter_in,
    output wire [1:0] phase_sel_out,
    output wire amp_stage_en_out,
    output wire illum_en_out,
    output wire low_sens_out,
    input wire pix_valid_in,
    output wire pix_ready_out,
    input wire [11:0] pix_data_in,
    input wire pix_sat_in,
    input wire [63:0] temp_in,
    output wire video_valid_out,
    input wire video_ready_in,
    output wire [11:0] video_data_out,
    output wire video_sat_out,
    output reg vsync_out
);
    localparam I_IDLE = 3'h0, I_ADDR = 3'h1, I_AACK = 3'h2, I_WR = 3'h3;
    localparam I_WACK = 3'h4, I_RD = 3'h5, I_RACK = 3'h6;
    localparam A_IDLE = 2'h0, A_INT = 2'h1, A_READ = 2'h2, A_DONE = 2'h3;

    reg [2:0] scl_s;
    reg [2:0] sda_s;
    reg [2:0] sh_s;
    reg [2:0] istate;
    reg [3:0] bitcnt;
    reg [7:0] rx;
    reg [7:0] tx;
    reg rw;
    reg ptr_set;
    reg [7:0] ptr;
    reg [7:0] rdata;
    reg [7:0] gray_cfg;
    reg [7:0] mode;
    reg sw_trig;
    wire [63:0] temp_word;
    wire [15:0] temp_sel;
    reg [1:0] astate;
    reg [2:0] phase;
    reg [31:0] cnt;
    wire scl_rise;
    wire scl_fall;
    wire start_c;
    wire stop_c;
    wire gray;
    wire [2:0] nphase;
    wire fifo_ready;
    wire push;
    wire [12:0] fifo_out;
    wire trig;

    // two-flop sync; only stage 1 onward feeds logic
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            sh_s <= 3'h0;
        end
        else
        begin
            scl_s <= {scl_s[1:0], i2c_scl_in};
            sda_s <= {sda_s[1:0], i2c_sda_in};
            sh_s <= {sh_s[1:0], shutter_in};
        end
    end

    assign scl_rise = scl_s[1] && !scl_s[2];
    assign scl_fall = !scl_s[1] && scl_s[2];
    assign start_c = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
    assign stop_c = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
    assign i2c_sda_out = 1'b0;
    // pointer bits 2:1 pick the sensor, bit 0 the byte
    assign temp_sel = temp_word[{ptr[2:1], 4'h0} +: 16];

    // read mux: temps as high/low pairs, cal bytes, config
    always @*
    begin
        rdata = 8'h00;
        if (ptr >= `GTR_ADDR_TEMP_BASE && ptr <= `GTR_ADDR_TEMP_LAST)
            rdata = ptr[0] ? temp_sel[7:0] : temp_sel[15:8];
        else if (ptr == `GTR_ADDR_GRAY_CFG)
            rdata = gray_cfg;
        else if (ptr == `GTR_ADDR_MODE)
            rdata = mode;
        else if (ptr == `GTR_ADDR_CAL_BASE)
            rdata = CAL0;
        else if (ptr == `GTR_ADDR_CAL_BASE + 8'h02)
            rdata = CAL1;
        else if (ptr == `GTR_ADDR_CAL_BASE + 8'h04)
            rdata = CAL2;
        else if (ptr == `GTR_ADDR_CAL_BASE + 8'h06)
            rdata = CAL3;
    end

    // i2c slave: first written byte sets pointer, then auto-increment
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            istate <= I_IDLE;
            bitcnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            rw <= 1'b0;
            ptr_set <= 1'b0;
            ptr <= 8'h00;
            gray_cfg <= `GTR_GRAY_CFG_RESET;
            mode <= `GTR_MODE_RESET;
            sw_trig <= 1'b0;
            i2c_sda_oe_out <= 1'b0;
        end
        else
        begin
            sw_trig <= 1'b0;
            if (start_c)
            begin
                istate <= I_ADDR;
                bitcnt <= 4'h0;
                i2c_sda_oe_out <= 1'b0;
            end
            else if (stop_c)
            begin
                istate <= I_IDLE;
                i2c_sda_oe_out <= 1'b0;
            end
            else
            begin
                case (istate)
                    I_ADDR, I_WR:
                    begin
                        if (scl_rise && bitcnt != 4'h8)
                        begin
                            rx <= {rx[6:0], sda_s[1]};
                            bitcnt <= bitcnt + 4'h1;
                        end
                        else if (scl_fall && bitcnt == 4'h8)
                        begin
                            bitcnt <= 4'h0;
                            if (istate == I_ADDR)
                            begin
                                if (rx[7:1] == `GTR_I2C_DEV_ADDR)
                                begin
                                    i2c_sda_oe_out <= 1'b1;
                                    rw <= rx[0];
                                    ptr_set <= 1'b0;
                                    istate <= I_AACK;
                                end
                                else
                                    istate <= I_IDLE;
                            end
                            else
                            begin
                                i2c_sda_oe_out <= 1'b1;
                                istate <= I_WACK;
                                if (!ptr_set)
                                begin
                                    ptr <= rx;
                                    ptr_set <= 1'b1;
                                end
                                else
                                begin
                                    ptr <= ptr + 8'h01;
                                    if (ptr == `GTR_ADDR_GRAY_CFG)
                                        gray_cfg <= rx;
                                    if (ptr == `GTR_ADDR_MODE)
                                        mode <= rx;
                                    if (ptr == `GTR_ADDR_TRIGGER)
                                        sw_trig <= (rx == `GTR_TRIGGER_CMD);
                                end
                            end
                        end
                    end
                    I_AACK, I_WACK, I_RACK:
                    begin
                        if (istate == I_RACK && scl_rise && sda_s[1])
                            istate <= I_IDLE; // master nack ends the read
                        else if (scl_fall)
                        begin
                            if (istate == I_WACK || !rw)
                            begin
                                i2c_sda_oe_out <= 1'b0;
                                istate <= I_WR;
                            end
                            else
                            begin
                                tx <= rdata;
                                i2c_sda_oe_out <= ~rdata[7];
                                bitcnt <= 4'h1;
                                ptr <= ptr + 8'h01;
                                istate <= I_RD;
                            end
                        end
                    end
                    I_RD:
                    begin
                        if (scl_fall)
                        begin
                            if (bitcnt == 4'h8)
                            begin
                                i2c_sda_oe_out <= 1'b0;
                                istate <= I_RACK;
                            end
                            else
                            begin
                                tx <= {tx[6:0], 1'b0};
                                i2c_sda_oe_out <= ~tx[6];
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    default:
                        i2c_sda_oe_out <= 1'b0;
                endcase
            end
        end
    end

    assign gray = (mode == `GTR_MODE_GRAYSCALE);
    assign nphase = gray ? `GTR_PHASES_GRAY : `GTR_PHASES_NORMAL;
    assign trig = sw_trig || (sh_s[1] && !sh_s[2]);
    assign push = (astate == A_READ) && pix_valid_in && fifo_ready;
    assign pix_ready_out = (astate == A_READ) && fifo_ready;
    assign phase_sel_out = phase[1:0];
    // amplifier held for the whole integration in grayscale
    assign amp_stage_en_out = gray && (astate == A_INT);
    assign illum_en_out = (astate == A_INT)
        && (!gray || gray_cfg[`GTR_CFG_ILLUM_BIT]);
    assign low_sens_out = gray && (astate != A_IDLE);

    // acquisition sequencer; triggers outside idle are ignored
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            astate <= A_IDLE;
            phase <= 3'h0;
            cnt <= 32'h0;
            vsync_out <= 1'b0;
        end
        else
        begin
            case (astate)
                A_IDLE:
                    if (trig)
                    begin
                        vsync_out <= 1'b0;
                        phase <= 3'h0;
                        cnt <= 32'h0;
                        astate <= A_INT;
                    end
                A_INT:
                    if (cnt == INT_CYCLES - 1)
                    begin
                        cnt <= 32'h0;
                        astate <= A_READ;
                    end
                    else
                        cnt <= cnt + 32'h1;
                A_READ:
                    if (push)
                    begin
                        if (cnt == PIXELS - 1)
                        begin
                            cnt <= 32'h0;
                            if (phase == nphase - 3'h1)
                                astate <= A_DONE;
                            else
                            begin
                                phase <= phase + 3'h1;
                                astate <= A_INT;
                            end
                        end
                        else
                            cnt <= cnt + 32'h1;
                    end
                A_DONE:
                    if (!video_valid_out)
                    begin
                        vsync_out <= 1'b1;
                        astate <= A_IDLE;
                    end
                default:
                    astate <= A_IDLE;
            endcase
        end
    end

    // latch sensor words at end of grayscale read; one owner per word
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : tsens
            reg [15:0] word;
            always @(posedge ref_clk_in)
            begin
                if (sys_rst_in)
                    word <= 16'h0000;
                else if (push && gray && cnt == PIXELS - 1)
                    word <= temp_in[16*g+15:16*g];
            end
            assign temp_word[16*g+15:16*g] = word;
        end
    endgenerate

    // signed 12-bit passes unclipped; sat flag rides with each pixel
    gtr_fifo #(
        .WIDTH(13),
        .DEPTH(16),
        .AW(4)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(push),
        .in_ready_out(fifo_ready),
        .in_data_in({pix_sat_in, pix_data_in}),
        .out_valid_out(video_valid_out),
        .out_ready_in(video_ready_in),
        .out_data_out(fifo_out)
    );

    assign video_data_out = fifo_out[11:0];
    assign video_sat_out = fifo_out[12];
endmodule
